// ---- rtl/ufs_pkg.sv ----
// package for the uart fifo, status and interrupt block
// assumes one 50 MHz system clock and 8-bit characters
package ufs_pkg;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned FIFO_DEPTH   = 32;
   localparam int unsigned CNT_W        = 6;
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned BAUD_DEFAULT = 115_200;
   // bit time in clock cycles, rounded down
   localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD_DEFAULT;
   localparam int unsigned HALF_CYCLES  = BIT_CYCLES / 2;
   localparam int unsigned BITCNT_W     = 10;
   localparam logic [CNT_W-1:0] RX_TRIG_RESET = 6'h08;
   localparam logic [CNT_W-1:0] TX_TRIG_RESET = 6'h08;
   typedef enum logic [1:0] {
      UFS_IDLE,
      UFS_START,
      UFS_DATA,
      UFS_STOP
   } ufs_line_e;
endpackage : ufs_pkg

// ---- rtl/ufs_fifo.sv ----
// synchronous fifo with valid/ready on both sides and a flush input
// assumes one clock, synchronous active-low reset
module ufs_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire logic                     flush,
   // fill side
   input  wire logic                     inValid,
   output logic                          inReady,
   input  wire logic [WIDTH-1:0]         inData,
   // drain side
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [WIDTH-1:0]              outData,
   // fill level
   output logic [$clog2(DEPTH):0]        count
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign inReady  = (cnt_q != (AW+1)'(DEPTH));
   assign outValid = (cnt_q != '0);
   assign outData  = mem[rdPtr_q];
   assign count    = cnt_q;
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_comb begin
      wrPtr_d = wrPtr_q + AW'(push);
      rdPtr_d = rdPtr_q + AW'(pop);
      cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         wrPtr_d = '0;
         rdPtr_d = '0;
         cnt_d   = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q   <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         cnt_q   <= cnt_d;
      end
   end

   // storage has no reset, only written on push
   always_ff @(posedge clk_sys) begin
      if (push && !flush) begin
         mem[wrPtr_q] <= inData;
      end
   end
endmodule : ufs_fifo

// ---- rtl/ufs_uart.sv ----
// uart fifo, status and interrupt side with simple serial engines
// assumes one 50 MHz clock, rx pin already synchronised, 8N1 framing
//
// Functional notes
// - completed received characters with a good stop bit enter receive fifo
// - written characters queue, sent when transmit enabled
// - data available while receive fifo non-empty
// - data read returns and pops oldest character
// - framing errors detected and reported in status
// - transmit half-empty trigger programmable, default 8
// - transmit interrupt gated by its enable bit
// - receive interrupt waits for trigger count reached
// - write ready is one unless transmit fifo full
// - fifo clear bits empty the matching fifo
// - receive half-full trigger programmable, default 8
// - character into full receive fifo flags overflow
module ufs_uart
   import ufs_pkg::*;
(
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // enables and configuration
   input  wire logic                        rxEnable,
   input  wire logic                        txEnable,
   input  wire logic                        irqRxEnable,
   input  wire logic                        irqTxEnable,
   input  wire logic                        trigWrite,
   input  wire logic [ufs_pkg::CNT_W-1:0]   rxTrigIn,
   input  wire logic [ufs_pkg::CNT_W-1:0]   txTrigIn,
   input  wire logic                        rxFifoClear,
   input  wire logic                        txFifoClear,
   input  wire logic                        errorClear,
   // data register access
   input  wire logic                        dataWrite,
   input  wire logic [ufs_pkg::DATA_W-1:0]  dataWriteValue,
   input  wire logic                        dataRead,
   output logic      [ufs_pkg::DATA_W-1:0]  dataReadValue_q,
   // status
   output logic                             rxDataAvailable_q,
   output logic                             txWriteReady_q,
   output logic                             rxFramingError_q,
   output logic                             rxOverflow_q,
   output logic                             txBusy_q,
   output logic                             irq_q,
   // serial pins
   input  wire logic                        rxPin,
   output logic                             txPin_q
);
   import ufs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // fifos
   logic              rxPush, rxInReady, rxValid, rxPop;
   logic [DATA_W-1:0] rxChar, rxHead;
   logic [CNT_W-1:0]  rxCount, txCount;
   logic              txInReady, txValid, txPop;
   logic [DATA_W-1:0] txHead;

   ufs_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) uRxFifo (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .flush   (rxFifoClear),
      .inValid (rxPush),
      .inReady (rxInReady),
      .inData  (rxChar),
      .outValid(rxValid),
      .outReady(rxPop),
      .outData (rxHead),
      .count   (rxCount)
   );

   ufs_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) uTxFifo (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .flush   (txFifoClear),
      .inValid (dataWrite),
      .inReady (txInReady),
      .inData  (dataWriteValue),
      .outValid(txValid),
      .outReady(txPop),
      .outData (txHead),
      .count   (txCount)
   );

   assign rxPop = dataRead & rxValid;

   ////////////////////////////////////////////////////////////////////////////
   // receive engine
   ufs_line_e            rxSt_q, rxSt_d;
   logic [BITCNT_W-1:0]  rxTim_q, rxTim_d;
   logic [2:0]           rxBit_q, rxBit_d;
   logic [DATA_W-1:0]    rxSh_q, rxSh_d;
   logic                 rxDone, rxFrameBad;

   always_comb begin
      rxSt_d     = rxSt_q;
      rxTim_d    = rxTim_q;
      rxBit_d    = rxBit_q;
      rxSh_d     = rxSh_q;
      rxDone     = 1'b0;
      rxFrameBad = 1'b0;
      unique case (rxSt_q)
         UFS_IDLE: begin
            if (rxEnable && !rxPin) begin
               rxSt_d  = UFS_START;
               rxTim_d = BITCNT_W'(HALF_CYCLES);
            end
         end
         UFS_START: begin
            if (rxTim_q == '0) begin
               rxSt_d  = rxPin ? UFS_IDLE : UFS_DATA;
               rxTim_d = BITCNT_W'(BIT_CYCLES - 1);
               rxBit_d = '0;
            end else begin
               rxTim_d = rxTim_q - 1'b1;
            end
         end
         UFS_DATA: begin
            if (rxTim_q == '0) begin
               rxSh_d  = {rxPin, rxSh_q[DATA_W-1:1]};
               rxTim_d = BITCNT_W'(BIT_CYCLES - 1);
               rxBit_d = rxBit_q + 1'b1;
               if (rxBit_q == 3'h7) begin
                  rxSt_d = UFS_STOP;
               end
            end else begin
               rxTim_d = rxTim_q - 1'b1;
            end
         end
         UFS_STOP: begin
            if (rxTim_q == '0) begin
               rxSt_d     = UFS_IDLE;
               rxDone     = 1'b1;
               rxFrameBad = !rxPin;
            end else begin
               rxTim_d = rxTim_q - 1'b1;
            end
         end
      endcase
   end

   // only a finished character is stored, never a partial one
   assign rxChar = rxSh_q;
   assign rxPush = rxDone & !rxFrameBad;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rxSt_q  <= UFS_IDLE;
         rxTim_q <= '0;
         rxBit_q <= '0;
         rxSh_q  <= '0;
      end else begin
         rxSt_q  <= rxSt_d;
         rxTim_q <= rxTim_d;
         rxBit_q <= rxBit_d;
         rxSh_q  <= rxSh_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit engine
   ufs_line_e            txSt_q, txSt_d;
   logic [BITCNT_W-1:0]  txTim_q, txTim_d;
   logic [2:0]           txBit_q, txBit_d;
   logic [DATA_W-1:0]    txSh_q, txSh_d;
   logic                 txPin_d;

   always_comb begin
      txSt_d  = txSt_q;
      txTim_d = txTim_q;
      txBit_d = txBit_q;
      txSh_d  = txSh_q;
      txPin_d = 1'b1;
      txPop   = 1'b0;
      unique case (txSt_q)
         UFS_IDLE: begin
            if (txEnable && txValid) begin
               txPop   = 1'b1;
               txSh_d  = txHead;
               txSt_d  = UFS_START;
               txTim_d = BITCNT_W'(BIT_CYCLES - 1);
               txPin_d = 1'b0;
            end
         end
         UFS_START: begin
            txPin_d = 1'b0;
            if (txTim_q == '0) begin
               txSt_d  = UFS_DATA;
               txTim_d = BITCNT_W'(BIT_CYCLES - 1);
               txBit_d = '0;
               txPin_d = txSh_q[0];
            end else begin
               txTim_d = txTim_q - 1'b1;
            end
         end
         UFS_DATA: begin
            txPin_d = txSh_q[0];
            if (txTim_q == '0) begin
               txTim_d = BITCNT_W'(BIT_CYCLES - 1);
               txSh_d  = {1'b1, txSh_q[DATA_W-1:1]};
               txBit_d = txBit_q + 1'b1;
               txPin_d = txSh_q[1];
               if (txBit_q == 3'h7) begin
                  txSt_d  = UFS_STOP;
                  txPin_d = 1'b1;
               end
            end else begin
               txTim_d = txTim_q - 1'b1;
            end
         end
         UFS_STOP: begin
            if (txTim_q == '0) begin
               txSt_d = UFS_IDLE;
            end else begin
               txTim_d = txTim_q - 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         txSt_q  <= UFS_IDLE;
         txTim_q <= '0;
         txBit_q <= '0;
         txSh_q  <= '0;
         txPin_q <= 1'b1;
      end else begin
         txSt_q  <= txSt_d;
         txTim_q <= txTim_d;
         txBit_q <= txBit_d;
         txSh_q  <= txSh_d;
         txPin_q <= txPin_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status, triggers and interrupt
   logic [CNT_W-1:0]  rxTrig_q, rxTrig_d, txTrig_q, txTrig_d;
   logic              frErr_d, ovf_d, irq_d, rxIrqCond, txIrqCond;
   logic [DATA_W-1:0] rdVal_d;
   logic              rxLost;

   // a clean character finishing into a full fifo is dropped
   assign rxLost    = rxPush & !rxInReady;
   assign rxIrqCond = (rxCount >= rxTrig_q);
   assign txIrqCond = (txCount < txTrig_q);

   always_comb begin
      rxTrig_d = trigWrite ? rxTrigIn : rxTrig_q;
      txTrig_d = trigWrite ? txTrigIn : txTrig_q;
      // set wins over a clear in the same cycle
      frErr_d  = (rxFrameBad & rxDone) | (rxFramingError_q & !errorClear);
      ovf_d    = rxLost | (rxOverflow_q & !errorClear);
      irq_d    = (irqRxEnable & rxIrqCond) | (irqTxEnable & txIrqCond);
      rdVal_d  = rxPop ? rxHead : dataReadValue_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rxTrig_q          <= RX_TRIG_RESET;
         txTrig_q          <= TX_TRIG_RESET;
         rxFramingError_q  <= 1'b0;
         rxOverflow_q      <= 1'b0;
         irq_q             <= 1'b0;
         dataReadValue_q   <= '0;
         rxDataAvailable_q <= 1'b0;
         // fifo is empty out of reset, so write ready already reads one
         txWriteReady_q    <= 1'b1;
         txBusy_q          <= 1'b0;
      end else begin
         rxTrig_q          <= rxTrig_d;
         txTrig_q          <= txTrig_d;
         rxFramingError_q  <= frErr_d;
         rxOverflow_q      <= ovf_d;
         irq_q             <= irq_d;
         dataReadValue_q   <= rdVal_d;
         rxDataAvailable_q <= rxValid;
         txWriteReady_q    <= txInReady;
         txBusy_q          <= (txSt_q != UFS_IDLE) | txValid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_RX_AVAIL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxDataAvailable_q == $past(rxValid)) else $error("rx available wrong");
   AST_TX_READY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      txWriteReady_q == $past(txCount != CNT_W'(FIFO_DEPTH)))
      else $error("write ready wrong");
   AST_TX_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!$past(irqTxEnable) && !$past(irqRxEnable)) |-> !irq_q)
      else $error("irq without enable");
   AST_RX_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!$past(irqTxEnable) && $past(irqRxEnable))
      |-> irq_q == $past(rxCount >= rxTrig_q)) else $error("rx irq level");
   AST_FLUSH_RX: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxFifoClear |=> rxCount == '0) else $error("rx clear failed");
   AST_FLUSH_TX: assert property (@(posedge clk_sys) disable iff (!rst_n)
      txFifoClear |=> txCount == '0) else $error("tx clear failed");
   AST_OVERFLOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxLost |=> rxOverflow_q) else $error("overflow not flagged");
   AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rxPop |=> dataReadValue_q == $past(rxHead)) else $error("read data wrong");
   AST_TX_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !txEnable && txSt_q == UFS_IDLE |-> !txPop) else $error("sent while disabled");
   AST_FRAME: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rxDone && rxFrameBad) |=> rxFramingError_q) else $error("frame error lost");
endmodule : ufs_uart

// ---- verification/ufs_remote_node.sv ----
// remote serial node: frames characters onto the block's receive pin, decodes its transmit pin
// assumes 8N1 framing at BIT_CYCLES clocks per bit and the block's own clock
module ufs_remote_node (
   // clock
   input  wire logic clk_sys,
   // serial line
   output logic      rxLine,
   input  wire logic txLine
);
   timeunit 1ns;
   timeprecision 1ns;
   import ufs_pkg::*;

   logic [7:0] gotQ[$];
   logic [7:0] shiftV;

   initial begin
      rxLine = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // a bad stop rises before the next mid-bit, so any false start it causes is rejected
   task automatic sendChar(input logic [7:0] v, input logic goodStop);
      @(posedge clk_sys) rxLine <= 1'b0;
      repeat (BIT_CYCLES) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         rxLine <= v[i];
         repeat (BIT_CYCLES) @(posedge clk_sys);
      end
      rxLine <= goodStop;
      repeat (HALF_CYCLES + 40) @(posedge clk_sys);
      rxLine <= 1'b1;
      repeat (BIT_CYCLES - HALF_CYCLES - 40) @(posedge clk_sys);
   endtask : sendChar

   ////////////////////////////////////////////////////////////////////////////////
   // receiver samples mid-bit; a bad stop is stored inverted so it cannot match
   initial begin
      forever begin
         @(posedge clk_sys);
         if (txLine === 1'b0) begin
            repeat (HALF_CYCLES) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYCLES) @(posedge clk_sys);
               shiftV[i] = txLine;
            end
            repeat (BIT_CYCLES) @(posedge clk_sys);
            if (txLine === 1'b1) gotQ.push_back(shiftV);
            else gotQ.push_back(~shiftV);
         end
      end
   end
endmodule : ufs_remote_node

// ---- verification/uart_fifo_status_irq_bench.sv ----
// self-checking bench for the uart fifo, status and interrupt block
// assumes the remote node model on the serial pins and one 50 MHz clock
module uart_fifo_status_irq_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ufs_pkg::*;

   logic              clk_sys, rst_n, rxEnable, txEnable, irqRxEnable, irqTxEnable;
   logic              trigWrite, rxFifoClear, txFifoClear, errorClear, dataWrite, dataRead;
   logic [CNT_W-1:0]  rxTrigIn, txTrigIn;
   logic [DATA_W-1:0] dataWriteValue, dataReadValue_q;
   logic              rxDataAvailable_q, txWriteReady_q, rxFramingError_q, rxOverflow_q;
   logic              txBusy_q, irq_q, rxPin, txPin_q;
   int                err_count, samples_checked, n;

   ufs_uart u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .rxEnable(rxEnable), .txEnable(txEnable),
      .irqRxEnable(irqRxEnable), .irqTxEnable(irqTxEnable), .trigWrite(trigWrite),
      .rxTrigIn(rxTrigIn), .txTrigIn(txTrigIn), .rxFifoClear(rxFifoClear),
      .txFifoClear(txFifoClear), .errorClear(errorClear), .dataWrite(dataWrite),
      .dataWriteValue(dataWriteValue), .dataRead(dataRead), .dataReadValue_q(dataReadValue_q),
      .rxDataAvailable_q(rxDataAvailable_q), .txWriteReady_q(txWriteReady_q),
      .rxFramingError_q(rxFramingError_q), .rxOverflow_q(rxOverflow_q), .txBusy_q(txBusy_q),
      .irq_q(irq_q), .rxPin(rxPin), .txPin_q(txPin_q));

   ufs_remote_node u_node (.clk_sys(clk_sys), .rxLine(rxPin), .txLine(txPin_q));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic idle(input int cyc);
      repeat (cyc) @(posedge clk_sys);
      #1;
   endtask : idle

   task automatic wrChar(input logic [7:0] v);
      @(posedge clk_sys);
      dataWrite      <= 1'b1;
      dataWriteValue <= v;
      @(posedge clk_sys);
      dataWrite <= 1'b0;
   endtask : wrChar

   task automatic rdChar(input logic [7:0] exp);
      @(posedge clk_sys);
      dataRead <= 1'b1;
      @(posedge clk_sys);
      dataRead <= 1'b0;
      #1;
      check(dataReadValue_q, exp);
   endtask : rdChar

   // 0 rx clear, 1 tx clear, 2 error clear, 3 trigger load
   task automatic strobe(input int which);
      @(posedge clk_sys);
      case (which)
         0: rxFifoClear <= 1'b1;
         1: txFifoClear <= 1'b1;
         2: errorClear  <= 1'b1;
         default: trigWrite <= 1'b1;
      endcase
      @(posedge clk_sys);
      {rxFifoClear, txFifoClear, errorClear, trigWrite} <= 4'h0;
   endtask : strobe

   initial begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      $display("wrong value at %0t: run did not finish", $time);
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, rxEnable, txEnable, irqRxEnable, irqTxEnable, trigWrite} = 6'h00;
      {rxFifoClear, txFifoClear, errorClear, dataWrite, dataRead} = 5'h00;
      {rxTrigIn, txTrigIn, dataWriteValue} = 20'h0_0000;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      idle(2);
      check(8'(txPin_q), 8'h01);
      check(8'(txWriteReady_q), 8'h01);
      check(8'(irq_q), 8'h00);
      // transmit trigger boundary, gating and full fifo
      @(posedge clk_sys) irqTxEnable <= 1'b1;
      idle(2);
      check(8'(irq_q), 8'h01);
      for (int i = 0; i < 7; i++) wrChar(8'(i));
      idle(2);
      check(8'(irq_q), 8'h01);
      check(8'(txPin_q), 8'h01);
      wrChar(8'h07);
      idle(2);
      check(8'(irq_q), 8'h00);
      for (int i = 8; i < 33; i++) wrChar(8'(i));
      idle(2);
      check(8'(txWriteReady_q), 8'h00);
      strobe(1);
      idle(2);
      check(8'(txWriteReady_q), 8'h01);
      check(8'(txBusy_q), 8'h00);
      check(8'(irq_q), 8'h01);
      @(posedge clk_sys) irqTxEnable <= 1'b0;
      idle(2);
      check(8'(irq_q), 8'h00);
      $display("test transmit fifo done");
      // queued characters leave only once enabled
      wrChar(8'ha5);
      wrChar(8'h3c);
      idle(5);
      check(8'(txPin_q), 8'h01);
      @(posedge clk_sys) txEnable <= 1'b1;
      idle(2);
      check(8'(txPin_q), 8'h00);
      check(8'(txBusy_q), 8'h01);
      n = 0;
      while (u_node.gotQ.size() < 2 && n < 12000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 12000) begin
         err_count++;
         $display("wrong value at %0t: transmit line timed out", $time);
         end_sim();
      end
      check(u_node.gotQ.pop_front(), 8'ha5);
      check(u_node.gotQ.pop_front(), 8'h3c);
      @(posedge clk_sys) txEnable <= 1'b0;
      $display("test transmit line done");
      // receive fill, default trigger, drain in order
      @(posedge clk_sys) rxEnable <= 1'b1;
      irqRxEnable <= 1'b1;
      for (int i = 0; i < 7; i++) u_node.sendChar(8'(8'h40 + i), 1'b1);
      idle(3);
      check(8'(rxDataAvailable_q), 8'h01);
      check(8'(irq_q), 8'h00);
      u_node.sendChar(8'h47, 1'b1);
      idle(3);
      check(8'(irq_q), 8'h01);
      for (int i = 0; i < 6; i++) rdChar(8'(8'h40 + i));
      idle(2);
      check(8'(irq_q), 8'h00);
      @(posedge clk_sys) rxTrigIn <= 6'h02;
      strobe(3);
      idle(2);
      check(8'(irq_q), 8'h01);
      rdChar(8'h46);
      idle(2);
      check(8'(irq_q), 8'h00);
      rdChar(8'h47);
      idle(2);
      check(8'(rxDataAvailable_q), 8'h00);
      rdChar(8'h47);
      $display("test receive fifo done");
      // bad stop bit is flagged and not stored
      u_node.sendChar(8'h55, 1'b0);
      idle(3);
      check(8'(rxFramingError_q), 8'h01);
      check(8'(rxDataAvailable_q), 8'h00);
      strobe(2);
      idle(2);
      check(8'(rxFramingError_q), 8'h00);
      // receive clear empties the fifo
      u_node.sendChar(8'h99, 1'b1);
      idle(3);
      check(8'(rxDataAvailable_q), 8'h01);
      strobe(0);
      idle(2);
      check(8'(rxDataAvailable_q), 8'h00);
      check(8'(rxOverflow_q), 8'h00);
      $display("test receive errors done");
      end_sim();
   end
endmodule : uart_fifo_status_irq_bench
